// File: dv/serial_flash_protect_status_props.sv
// checker on the top ports, core clock domain
module serial_flash_protect_status_props
  import serial_flash_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // link and configuration
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  input wire logic [3:0] io_oe_o,
  input wire logic io3_reset_en_i,
  // array sequencer
  input wire logic array_req_valid_o,
  input wire logic array_fail_i,
  // status
  input wire logic [7:0] status1_o,
  input wire logic [7:0] config1_o,
  input wire logic hw_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_oe_idle: assert property (cs_n_i && $past(cs_n_i) |-> io_oe_o == 4'h0)
    else $error("data lines driven while deselected");
  a_oe_code: assert property (io_oe_o inside {4'h0, 4'h2, 4'hf})
    else $error("illegal output enable pattern");
  a_req_single: assert property (array_req_valid_o |=> (!array_req_valid_o)[*4])
    else $error("array request not a single pulse");
  a_req_busy: assert property (array_req_valid_o |-> ##[0:1] status1_o[ST_WIP])
    else $error("busy flag missing after request");
  a_fail_flag: assert property (array_fail_i && status1_o[ST_WIP]
    |=> ##[0:1] (status1_o[ST_PROG_ERR] || status1_o[ST_ERASE_ERR]) && status1_o[ST_WIP])
    else $error("failure not reported");
  a_err_busy: assert property (status1_o[ST_PROG_ERR] || status1_o[ST_ERASE_ERR]
    |-> status1_o[ST_WIP])
    else $error("error flag without busy flag");
  a_freeze_bp: assert property (config1_o[CF_FREEZE] ##1 config1_o[CF_FREEZE]
    |-> $stable(status1_o & ST1_BP_MASK))
    else $error("protect bits changed while frozen");
  a_freeze_cfg: assert property (config1_o[CF_FREEZE] ##1 config1_o[CF_FREEZE]
    |-> $stable(config1_o & CF1_OTP_MASK))
    else $error("config bits changed while frozen");
  a_rst_gate: assert property ((io_i[3] || !io3_reset_en_i || !cs_n_i)[*6]
    |-> !hw_reset_o)
    else $error("reset without a deselected low line three");
  a_rst_pulse: assert property (hw_reset_o |=> !hw_reset_o)
    else $error("reset pulse too long");
endmodule // serial_flash_protect_status_props

bind serial_flash_protect_status serial_flash_protect_status_props u_props (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .io_i(io_i), .io_oe_o(io_oe_o),
  .io3_reset_en_i(io3_reset_en_i), .array_req_valid_o(array_req_valid_o),
  .array_fail_i(array_fail_i), .status1_o(status1_o), .config1_o(config1_o),
  .hw_reset_o(hw_reset_o));

// File: dv/serial_flash_protect_status_tb.sv
module serial_flash_protect_status_tb import serial_flash_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, sck, cs_n, array_req_valid_o, wdata_valid_o, hw_reset_o;
  logic io3_reset_en_i = 1'b0, array_done_i = 1'b0, array_fail_i = 1'b0, eval_ok_i = 1'b0;
  logic fail_next = 1'b0, all_quad_mode_i = 1'b0;
  logic [3:0] host_io, io_o, io_oe_o, io_i, dummy_cycles_i = 4'h8;
  logic [1:0] lock_scheme_sel_i = 2'h0;
  array_req_t array_req_o, last_req;
  logic [26:0] rd_addr_o;
  logic [7:0] wdata_o, status1_o, config1_o, rx;
  logic [8:0] wdata_idx_o;
  logic [7:0] bad [6] = '{8'hb0, 8'h3b, 8'h6b, 8'h32, 8'h0d, 8'hbd};
  int error_cnt = 0, tests_run = 0, req_cnt = 0, wcnt = 0, hw_cnt = 0, n;
  // array answers combinationally from its address
  wire logic [7:0] rd_data_i = rd_addr_o[7:0] ^ 8'h5a;
  // wire level from the device's enables; host drives the rest
  assign io_i = (io_oe_o & io_o) | (~io_oe_o & host_io);
  always #50 ref_clk_i = ~ref_clk_i;
  serial_flash_protect_status u_serial_flash_protect_status (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
    .all_quad_mode_i(all_quad_mode_i), .io3_reset_en_i(io3_reset_en_i),
    .dummy_cycles_i(dummy_cycles_i),
    .lock_scheme_sel_i(lock_scheme_sel_i), .array_req_valid_o(array_req_valid_o),
    .array_req_o(array_req_o), .array_done_i(array_done_i), .array_fail_i(array_fail_i),
    .eval_ok_i(eval_ok_i), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
    .wdata_valid_o(wdata_valid_o), .wdata_o(wdata_o), .wdata_idx_o(wdata_idx_o),
    .status1_o(status1_o), .config1_o(config1_o), .hw_reset_o(hw_reset_o));
  spi_host_model u_spi_host_model (.sck_o(sck), .cs_n_o(cs_n), .io_o(host_io),
    .dev_io_i(io_o), .dev_oe_i(io_oe_o));
  // array sequencer: finishes or fails two cycles after each request
  always begin
    @(posedge ref_clk_i);
    #1;
    if (array_req_valid_o === 1'b1) begin
      last_req = array_req_o;
      req_cnt++;
      repeat (2) @(posedge ref_clk_i);
      #1 array_done_i = ~fail_next;
      array_fail_i = fail_next;
      @(posedge ref_clk_i);
      #1 array_done_i = 1'b0;
      array_fail_i = 1'b0;
    end
  end
  always @(posedge sck) if (wdata_valid_o === 1'b1) wcnt++;
  always @(posedge ref_clk_i) if (hw_reset_o === 1'b1) hw_cnt++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one frame, then let the core execute it
  task automatic go(input logic [63:0] tx, input int nbits, input int nd = 0,
      input int ndum = 0, input int nrd = 0);
    u_spi_host_model.frame(tx, nbits, nd, ndum, nrd, rx);
    repeat (20) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wren();
    go({OP_WR_EN, 56'h0}, 8);
  endtask
  task automatic clr();
    go({OP_CLR_STAT, 56'h0}, 8);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #5000000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    wren();
    chk(status1_o, 8'h02);
    go({OP_RD_STAT1, 56'h0}, 8, 0, 0, 1);
    chk(rx, 8'h02);
    $display("test status done");
    fail_next = 1'b1;
    wren();
    go({OP_PROG, 32'h100, 8'haa, 16'h0}, 48);
    chk(status1_o & 8'h61, 8'h41);
    clr();
    chk(status1_o & 8'h61, 8'h00);
    wren();
    go({OP_ERASE_LARGE, 32'h0, 24'h0}, 40);
    chk(status1_o & 8'h61, 8'h21);
    clr();
    fail_next = 1'b0;
    $display("test errors done");
    wren();
    go({OP_WRITE_REGS, 8'h00, 8'h02, 40'h0}, 24);
    chk(config1_o, 8'h02);
    wren();
    go({OP_WRITE_REGS, 8'h0c, 48'h0}, 16);
    chk(status1_o & 8'h1c, 8'h0c);
    chk(config1_o, 8'h02);
    n = req_cnt;
    wren();
    go({OP_PROG, 32'h07ff_ff00, 8'h11, 16'h0}, 48);
    chk(status1_o & 8'h61, 8'h41);
    chk(32'(req_cnt), 32'(n));
    clr();
    wren();
    go({OP_PROG, 32'h0400_0010, 8'h22, 16'h0}, 48);
    chk(last_req.die, 1'b1);
    chk(last_req.addr[25:0], 26'h10);
    wren();
    go({OP_ERASE_SMALL, 32'h0010_0000, 24'h0}, 40);
    chk(status1_o & 8'h21, 8'h21);
    clr();
    wren();
    go({OP_ERASE_SMALL, 32'h0, 24'h0}, 40);
    chk(32'(last_req.op), 32'(ARR_ERASE_SMALL));
    $display("test protect done");
    foreach (bad[i]) begin
      n = req_cnt;
      wren();
      go({bad[i], 32'h0, 24'h0}, 48);
      chk(status1_o, 8'h0e);
      chk(32'(req_cnt), 32'(n));
    end
    wcnt = 0;
    wren();
    go({OP_PROG, 32'h0, 24'h0}, 40, 514);
    chk(32'(wcnt), 32'd512);
    chk(last_req.nbytes, 10'h200);
    eval_ok_i = 1'b1;
    wren();
    go({OP_EVAL_ERASE, 32'h0, 24'h0}, 40);
    go({OP_RD_STAT2, 56'h0}, 8, 0, 0, 1);
    chk(rx[ST2_EVAL_OK], 1'b1);
    for (int d = 4; d <= 8; d += 4) begin
      dummy_cycles_i = 4'(d);
      go({OP_RD_STAT1, 56'h0}, 8);
      go({OP_FAST_READ, 32'h123, 24'h0}, 40, 0, d, 1);
      chk(rx, 8'h79);
    end
    $display("test commands done");
    wren();
    go({OP_WRITE_REGS, 8'h0c, 8'h01, 40'h0}, 24);
    chk(config1_o, 8'h01);
    wren();
    go({OP_WRITE_REGS, 8'h00, 8'h2c, 40'h0}, 24);
    chk(status1_o & 8'h1c, 8'h0c);
    chk(config1_o & 8'h2c, 8'h00);
    n = req_cnt;
    wren();
    go({OP_OTP_PROG, 32'h0, 8'h55, 16'h0}, 48);
    chk(32'(req_cnt), 32'(n));
    io3_reset_en_i = 1'b1;
    u_spi_host_model.io3_pulse();
    repeat (10) @(posedge ref_clk_i);
    #1;
    chk(32'(hw_cnt), 32'd1);
    chk(config1_o[CF_FREEZE], 1'b0);
    lock_scheme_sel_i = 2'h1;
    wren();
    go({OP_WRITE_REGS, 8'h0c, 8'h2c, 40'h0}, 24);
    chk(config1_o & 8'h2c, 8'h00);
    wren();
    go({OP_OTP_PROG, 32'h0, 8'h55, 16'h0}, 48);
    chk(32'(last_req.op), 32'(ARR_OTP_PROGRAM));
    all_quad_mode_i = 1'b1;
    go({OP_RD_STAT1, 56'h0}, 8);
    wren();
    chk(status1_o[ST_WEL], 1'b0);
    $display("test freeze done");
    print_verdict();
  end
endmodule // serial_flash_protect_status_tb

// File: dv/spi_host_model.sv
// host controller: single lane, clock runs only inside frames
module spi_host_model (
  // link pins
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  // device side of the data lines
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: deselected, lines pulled up
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'hf;
  end
  // one sck period of 80 ns
  task automatic beat();
    #40 sck_o = 1'b1;
    #40 sck_o = 1'b0;
  endtask
  // header bits msb first, then counted page bytes, dummies, read bytes
  task automatic frame(input logic [63:0] tx, input int nbits, input int nd,
      input int ndum, input int nrd, output logic [7:0] rx);
    logic [7:0] b;
    rx = 8'h00;
    #7 cs_n_o = 1'b0;
    #30;
    for (int i = 0; i < nbits + nd * 8; i++) begin
      b = 8'(i / 8 - nbits / 8);
      io_o[0] = (i < nbits) ? tx[63 - i] : b[7 - i % 8];
      beat();
    end
    repeat (ndum) beat();
    for (int i = 0; i < nrd * 8; i++) begin
      #40 sck_o = 1'b1;
      rx = {rx[6:0], dev_oe_i[1] ? dev_io_i[1] : 1'bx};
      #40 sck_o = 1'b0;
    end
    // released line shows the inverse, not the last bit
    io_o[0] = ~io_o[0];
    #30 cs_n_o = 1'b1;
    #600;
  endtask
  // pull line three low while deselected
  task automatic io3_pulse();
    #13 io_o[3] = 1'b0;
    #250 io_o[3] = 1'b1;
    #400;
  endtask
endmodule // spi_host_model

// File: hw/serial_flash_pkg.sv
package serial_flash_pkg;
  // instruction codes
  localparam logic [7:0] OP_WRITE_REGS = 8'h01;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_RD_STAT1 = 8'h05;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_RD_STAT2 = 8'h07;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_ERASE_SMALL = 8'h20;
  localparam logic [7:0] OP_CLR_STAT = 8'h30;
  localparam logic [7:0] OP_RD_CONF1 = 8'h35;
  localparam logic [7:0] OP_OTP_PROG = 8'h42;
  localparam logic [7:0] OP_EVAL_ERASE = 8'hd0;
  localparam logic [7:0] OP_ERASE_LARGE = 8'hd8;
  localparam logic [7:0] OP_QUAD_READ = 8'heb;
  localparam logic [7:0] OP_QUAD_DDR_READ = 8'hed;
  // status register 1 and 2 bit positions
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_PROG_ERR = 6;
  localparam logic [7:0] ST1_BP_MASK = 8'h1c;
  localparam logic [7:0] ST1_NV_MASK = 8'h9c;
  localparam int ST2_EVAL_OK = 2;
  // config register 1 bit positions
  localparam int CF_FREEZE = 0;
  localparam int CF_QUAD = 1;
  localparam int CF_PARAM_LOC = 2;
  localparam int CF_BP_VOL = 3;
  localparam int CF_PROT_ORIGIN = 5;
  localparam logic [7:0] CF1_OTP_MASK = 8'h2c;
  // reset values of the nonvolatile registers
  localparam logic [7:0] STATUS1_NV_RST = 8'h00;
  localparam logic [7:0] CONFIG1_NV_RST = 8'h00;
  // framing, in serial clock beats
  localparam logic [12:0] INST_BEATS_SINGLE = 13'h0008;
  localparam logic [12:0] INST_BEATS_QUAD = 13'h0002;
  localparam logic [12:0] ADDR_BEATS_SINGLE = 13'h0020;
  localparam logic [12:0] ADDR_BEATS_QUAD = 13'h0008;
  localparam logic [12:0] ADDR_BEATS_DDR = 13'h0004;
  localparam logic [12:0] BEAT_MAX = 13'h1fff;
  // address space
  localparam int DIE_SEL_BIT = 26;
  localparam logic [27:0] ARRAY_BYTES = 28'h8000000;
  localparam logic [27:0] PARAM_REGION_BYTES = 28'h0008000;
  localparam logic [9:0] PAGE_BYTES = 10'h200;
  // array operations
  typedef enum logic [2:0] {ARR_PROGRAM, ARR_OTP_PROGRAM, ARR_ERASE_SMALL, ARR_ERASE_LARGE,
    ARR_EVAL} array_op_t;
  // one frame as seen at its end
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [7:0] data0;
    logic [7:0] data1;
    logic [9:0] nbytes;
  } frame_cmd_t;
  // request to the array sequencer
  typedef struct packed {
    array_op_t op;
    logic die;
    logic [26:0] addr;
    logic [9:0] nbytes;
  } array_req_t;
endpackage

// File: hw/serial_flash_protect_status.sv
module serial_flash_protect_status
  import serial_flash_pkg::*;
(
  // core clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // serial link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // configuration
  input wire logic all_quad_mode_i,
  input wire logic io3_reset_en_i,
  input wire logic [3:0] dummy_cycles_i,
  input wire logic [1:0] lock_scheme_sel_i,
  // array sequencer, core domain
  output logic array_req_valid_o,
  output array_req_t array_req_o,
  input wire logic array_done_i,
  input wire logic array_fail_i,
  input wire logic eval_ok_i,
  // array read and page data, link domain
  output logic [26:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic wdata_valid_o,
  output logic [7:0] wdata_o,
  output logic [8:0] wdata_idx_o,
  // status
  output logic [7:0] status1_o,
  output logic [7:0] config1_o,
  output logic hw_reset_o
);

  //////////////////////////////////////////////////////////////////////////////
  // link domain
  logic link_rst; // frame end or power reset
  logic [12:0] cnt; // rising edges in this frame
  logic [7:0] opcode; // instruction shifter
  logic [31:0] addr_s; // address, rising nibbles or bits
  logic [15:0] addr_r; // ddr rising nibbles
  logic [15:0] addr_f; // ddr falling nibbles
  logic [31:0] addr_ddr; // interleaved ddr address
  logic [31:0] addr_full; // address of this frame
  logic [7:0] in_sh; // incoming data byte
  logic [2:0] ib; // beats into the byte
  logic [7:0] data0, data1; // first two data bytes
  logic [9:0] nbytes; // data bytes taken
  logic [23:0] bundle_m, bundle_s; // core status, synchroniser
  logic [7:0] status2; // evaluate result, written in core domain, read in link domain
  logic qpi_m; // first stage of all-quad mode
  logic qpi_s; // all-quad mode in link domain
  logic [3:0] dum_m, dum_s; // dummy cycle count
  logic [7:0] out_sh; // outgoing byte
  logic [2:0] ob; // beats into outgoing byte
  logic out_on; // device drives the lines
  logic out_first; // next load is first byte
  logic [26:0] rd_next; // next array byte address
  frame_cmd_t frame_rec; // frame as it stood when select rose

  // frame decode
  logic quad_en, quad_ln, ddr, has_addr, arr_rd, st_rd, wr_in, use_dum;
  logic [12:0] inst_len, addr_end, dat_start;
  logic [7:0] st_byte;

  assign link_rst = cs_n_i | ~nrst_i;

  // core status into the serial domain, quasi-static during a frame
  always_ff @(posedge sck_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bundle_m <= 24'h000000;
      bundle_s <= 24'h000000;
      qpi_m <= 1'b0;
      qpi_s <= 1'b0;
      dum_m <= 4'h0;
      dum_s <= 4'h0;
    end else begin
      bundle_m <= {config1_o, status2, status1_o};
      bundle_s <= bundle_m;
      qpi_m <= all_quad_mode_i;
      qpi_s <= qpi_m;
      dum_m <= dummy_cycles_i;
      dum_s <= dum_m;
    end
  end
  // record the frame as select rises; the link reset clears the live registers then
  always_ff @(posedge cs_n_i or negedge nrst_i) begin
    if (!nrst_i) frame_rec <= '0;
    else frame_rec <= {cnt >= inst_len, opcode, addr_full, data0, data1, nbytes};
  end

  // decode of the captured instruction
  always_comb begin
    quad_en = bundle_s[23 - 7 + CF_QUAD] | qpi_s;
    arr_rd = 1'b0;
    st_rd = 1'b0;
    wr_in = 1'b0;
    has_addr = 1'b0;
    use_dum = 1'b0;
    ddr = 1'b0;
    st_byte = bundle_s[7:0];
    case (opcode)
      OP_READ: begin
        arr_rd = 1'b1;
        has_addr = 1'b1;
      end
      OP_FAST_READ: begin
        arr_rd = 1'b1;
        has_addr = 1'b1;
        use_dum = 1'b1;
      end
      OP_QUAD_READ, OP_QUAD_DDR_READ: begin
        arr_rd = quad_en;
        has_addr = quad_en;
        use_dum = 1'b1;
        ddr = quad_en & (opcode == OP_QUAD_DDR_READ);
      end
      OP_RD_STAT1: st_rd = 1'b1;
      OP_RD_STAT2: begin
        st_rd = 1'b1;
        st_byte = bundle_s[15:8];
      end
      OP_RD_CONF1: begin
        st_rd = 1'b1;
        st_byte = bundle_s[23:16];
      end
      OP_PROG, OP_OTP_PROG: begin
        wr_in = 1'b1;
        has_addr = 1'b1;
      end
      OP_WRITE_REGS: wr_in = 1'b1;
      OP_ERASE_SMALL, OP_ERASE_LARGE, OP_EVAL_ERASE: has_addr = 1'b1;
      default: begin
        // other codes carry nothing further
        has_addr = 1'b0;
      end
    endcase
    quad_ln = qpi_s | ddr | (arr_rd & (opcode[7:4] == OP_QUAD_READ[7:4]));
    inst_len = qpi_s ? INST_BEATS_QUAD : INST_BEATS_SINGLE;
    addr_end = inst_len + (ddr ? ADDR_BEATS_DDR : (quad_ln ? ADDR_BEATS_QUAD : ADDR_BEATS_SINGLE));
    dat_start = has_addr ? (addr_end + (use_dum ? {9'h000, dum_s} : 13'h0000)) : inst_len;
  end

  // rising edge: instruction, address, data in
  always_ff @(posedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      cnt <= 13'h0000;
      opcode <= 8'h00;
      addr_s <= 32'h00000000;
      addr_r <= 16'h0000;
      in_sh <= 8'h00;
      ib <= 3'h0;
      data0 <= 8'h00;
      data1 <= 8'h00;
      nbytes <= 10'h000;
      wdata_valid_o <= 1'b0;
      wdata_o <= 8'h00;
      wdata_idx_o <= 9'h000;
    end else begin
      // every edge counts up to BEAT_MAX, where the count holds; nothing pauses the frame
      if (cnt != BEAT_MAX) cnt <= cnt + 13'h0001;
      wdata_valid_o <= 1'b0;
      if (cnt < inst_len) begin
        // inputs taken on the rising edge, msb first
        opcode <= qpi_s ? {opcode[3:0], io_i} : {opcode[6:0], io_i[0]};
      end else if (has_addr && cnt < addr_end) begin
        if (ddr) addr_r <= {addr_r[11:0], io_i};
        else if (quad_ln) addr_s <= {addr_s[27:0], io_i};
        else addr_s <= {addr_s[30:0], io_i[0]};
      end else if (wr_in && cnt >= dat_start) begin
        ib <= ib + 3'h1;
        if (qpi_s) in_sh <= {in_sh[3:0], io_i};
        else in_sh <= {in_sh[6:0], io_i[0]};
        if ((qpi_s && ib[0]) || (!qpi_s && ib == 3'h7)) begin
          ib <= 3'h0;
          // page buffer stops taking bytes at its size
          if (nbytes != PAGE_BYTES) begin
            nbytes <= nbytes + 10'h001;
            wdata_valid_o <= 1'b1;
            wdata_idx_o <= nbytes[8:0];
            wdata_o <= qpi_s ? {in_sh[3:0], io_i} : {in_sh[6:0], io_i[0]};
            if (nbytes == 10'h000) data0 <= qpi_s ? {in_sh[3:0], io_i} : {in_sh[6:0], io_i[0]};
            if (nbytes == 10'h001) data1 <= qpi_s ? {in_sh[3:0], io_i} : {in_sh[6:0], io_i[0]};
          end
        end
      end
    end
  end

  // falling edge: ddr address nibbles and outgoing data
  always_ff @(negedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      addr_f <= 16'h0000;
      out_sh <= 8'h00;
      ob <= 3'h0;
      out_on <= 1'b0;
      out_first <= 1'b1;
      rd_next <= 27'h0000000;
    end else begin
      if (ddr && cnt > inst_len && cnt <= addr_end) addr_f <= {addr_f[11:0], io_i};
      // output changes on the falling edge once the latency is over
      if ((arr_rd || st_rd) && cnt >= dat_start) begin
        out_on <= 1'b1;
        ob <= ob + 3'h1;
        if (ob == 3'h0) begin
          out_sh <= st_rd ? st_byte : rd_data_i;
          out_first <= 1'b0;
          rd_next <= rd_addr_o + 27'h0000001;
        end else begin
          out_sh <= quad_ln ? {out_sh[3:0], 4'h0} : {out_sh[6:0], 1'b0};
        end
        if (ddr || (quad_ln && ob[0]) || (!quad_ln && ob == 3'h7)) ob <= 3'h0;
      end
    end
  end

  // ddr address: first rising nibble is most significant
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ddr_addr
      assign addr_ddr[8 * gi + 7 -: 4] = addr_r[4 * gi + 3 -: 4];
      assign addr_ddr[8 * gi + 3 -: 4] = addr_f[4 * gi + 3 -: 4];
    end
  endgenerate
  assign addr_full = ddr ? addr_ddr : addr_s;
  assign rd_addr_o = out_first ? addr_full[26:0] : rd_next;

  // line drive: ddr shows high nibble while clock low, low nibble while high
  always_comb begin
    io_o = 4'h0;
    io_oe_o = 4'h0;
    if (out_on) begin
      if (ddr) io_o = sck_i ? out_sh[3:0] : out_sh[7:4];
      else if (quad_ln) io_o = out_sh[7:4];
      else io_o = {2'h0, out_sh[7], 1'b0};
      io_oe_o = quad_ln ? 4'hf : 4'h2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core domain
  typedef enum {S_IDLE, S_BUSY, S_FAULT} core_state_t;
  core_state_t state; // sequencer state
  logic [2:0] cs_sync; // select synchroniser and edge stage
  logic [2:0] io3_sync; // line three synchroniser and edge stage
  frame_cmd_t cmd_q; // frame captured at its end
  logic exec; // one-cycle execute pulse
  logic [7:0] status1_volatile, status1_nonvolatile;
  logic [7:0] config1_volatile, config1_nonvolatile;
  logic [7:0] next_status1;
  array_op_t cur_op; // operation in flight
  logic run_ok, wel, freeze, lock_any, prot_hit, param_hit;
  logic is_prog, is_otp, is_es, is_el, is_eval, start_arr, fail_p, fail_e, issue, clr, wregs;
  logic [27:0] a28, prot_bytes;

  // select and line three into core clock
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_sync <= 3'h7;
      io3_sync <= 3'h7;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n_i};
      io3_sync <= {io3_sync[1:0], io_i[3]};
    end
  end

  // line three falling while deselected resets the device
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) hw_reset_o <= 1'b0;
    else hw_reset_o <= io3_reset_en_i & cs_sync[1] & cs_sync[2] & ~io3_sync[1] & io3_sync[2];
  end

  // take the recorded frame once select has risen; it stands still then
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_q <= '0;
      exec <= 1'b0;
    end else begin
      exec <= cs_sync[1] & ~cs_sync[2];
      if (cs_sync[1] & ~cs_sync[2]) begin
        cmd_q <= frame_rec;
      end
    end
  end

  // command decode and protection checks
  always_comb begin
    wel = status1_volatile[ST_WEL];
    freeze = config1_volatile[CF_FREEZE];
    lock_any = |lock_scheme_sel_i;
    run_ok = exec & cmd_q.valid & (state == S_IDLE) & ~hw_reset_o;
    is_prog = (cmd_q.opcode == OP_PROG) & (cmd_q.nbytes != 10'h000);
    is_otp = (cmd_q.opcode == OP_OTP_PROG) & (cmd_q.nbytes != 10'h000);
    is_es = cmd_q.opcode == OP_ERASE_SMALL;
    is_el = cmd_q.opcode == OP_ERASE_LARGE;
    is_eval = cmd_q.opcode == OP_EVAL_ERASE;
    a28 = {1'b0, cmd_q.addr[26:0]};
    prot_bytes = (status1_volatile[4:2] == 3'h0) ? 28'h0000000 :
      (ARRAY_BYTES >> (3'h7 - status1_volatile[4:2]));
    prot_hit = config1_volatile[CF_PROT_ORIGIN] ? (a28 < prot_bytes) :
      (a28 >= ARRAY_BYTES - prot_bytes);
    param_hit = config1_volatile[CF_PARAM_LOC] ? (a28 >= ARRAY_BYTES - PARAM_REGION_BYTES) :
      (a28 < PARAM_REGION_BYTES);
    start_arr = run_ok & ((wel & (is_prog | is_otp | is_es | is_el)) | is_eval);
    // otp area is guarded by freeze only, not by the lock scheme
    fail_p = (is_prog & prot_hit) | (is_otp & freeze);
    fail_e = (is_el & prot_hit) | (is_es & (prot_hit | ~param_hit));
    issue = start_arr & ~fail_p & ~fail_e;
    clr = exec & cmd_q.valid & (cmd_q.opcode == OP_CLR_STAT) & (state == S_FAULT);
    wregs = run_ok & wel & (cmd_q.opcode == OP_WRITE_REGS) & (cmd_q.nbytes != 10'h000);
  end

  // next value of volatile status 1
  always_comb begin
    next_status1 = status1_volatile;
    if (run_ok && cmd_q.opcode == OP_WR_EN) next_status1[ST_WEL] = 1'b1;
    if (run_ok && cmd_q.opcode == OP_WR_DIS) next_status1[ST_WEL] = 1'b0;
    if (wregs) begin
      next_status1[ST_WEL] = 1'b0;
      next_status1[7] = cmd_q.data0[7];
      if (!freeze) begin
        next_status1 = (next_status1 & ~ST1_BP_MASK) | (cmd_q.data0 & ST1_BP_MASK);
      end
    end
    if (clr) begin
      next_status1[ST_WIP] = 1'b0;
      next_status1[ST_PROG_ERR] = 1'b0;
      next_status1[ST_ERASE_ERR] = 1'b0;
    end
    if (issue) next_status1[ST_WIP] = 1'b1;
    if (state == S_BUSY && array_done_i) begin
      next_status1[ST_WIP] = 1'b0;
      next_status1[ST_WEL] = 1'b0;
    end
    // failures hold busy and the matching error bit
    if (start_arr && fail_p) next_status1[ST_PROG_ERR] = 1'b1;
    if (start_arr && fail_e) next_status1[ST_ERASE_ERR] = 1'b1;
    if (start_arr && (fail_p || fail_e)) next_status1[ST_WIP] = 1'b1;
    if (state == S_BUSY && array_fail_i) begin
      next_status1[ST_WIP] = 1'b1;
      if (cur_op == ARR_PROGRAM || cur_op == ARR_OTP_PROGRAM) next_status1[ST_PROG_ERR] = 1'b1;
      else next_status1[ST_ERASE_ERR] = 1'b1;
    end
  end

  // volatile status 1
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) status1_volatile <= STATUS1_NV_RST & ST1_NV_MASK;
    else if (hw_reset_o) status1_volatile <= status1_nonvolatile & ST1_NV_MASK;
    else status1_volatile <= next_status1;
  end

  // nonvolatile status 1: protect bits when they are the nonvolatile copy
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) status1_nonvolatile <= STATUS1_NV_RST;
    else if (wregs && !freeze && !config1_volatile[CF_BP_VOL]) begin
      status1_nonvolatile <= cmd_q.data0 & ST1_NV_MASK;
    end
  end

  // configuration 1, written only when a second byte came
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      config1_nonvolatile <= CONFIG1_NV_RST;
      config1_volatile <= CONFIG1_NV_RST & ~8'h01;
    end else if (hw_reset_o) begin
      config1_volatile <= config1_nonvolatile & ~8'h01;
    end else if (wregs && cmd_q.nbytes != 10'h001) begin
      config1_volatile[CF_QUAD] <= cmd_q.data1[CF_QUAD];
      config1_nonvolatile[CF_QUAD] <= cmd_q.data1[CF_QUAD];
      // freeze sets, clears only by reset
      config1_volatile[CF_FREEZE] <= freeze | cmd_q.data1[CF_FREEZE];
      // one-time bits: locked by freeze and by a chosen lock scheme
      if (!freeze && !lock_any) begin
        config1_nonvolatile <= (config1_nonvolatile | (cmd_q.data1 & CF1_OTP_MASK)) &
          ~8'h03 | ({6'h00, cmd_q.data1[CF_QUAD], 1'b0});
        config1_volatile <= (config1_volatile | (cmd_q.data1 & CF1_OTP_MASK)) & ~8'h03 |
          {6'h00, cmd_q.data1[CF_QUAD], freeze | cmd_q.data1[CF_FREEZE]};
      end
    end
  end

  // sequencer state
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) state <= S_IDLE;
    else if (hw_reset_o) state <= S_IDLE;
    else begin
      unique case (state)
        S_IDLE: begin
          if (issue) state <= S_BUSY;
          else if (start_arr) state <= S_FAULT;
        end
        S_BUSY: begin
          if (array_fail_i) state <= S_FAULT;
          else if (array_done_i) state <= S_IDLE;
        end
        S_FAULT: begin
          if (clr) state <= S_IDLE;
        end
      endcase
    end
  end

  // array request and evaluate result
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      array_req_valid_o <= 1'b0;
      array_req_o <= '0;
      cur_op <= ARR_PROGRAM;
      status2 <= 8'h00;
    end else begin
      array_req_valid_o <= issue;
      if (issue) begin
        cur_op <= is_prog ? ARR_PROGRAM : is_otp ? ARR_OTP_PROGRAM : is_es ? ARR_ERASE_SMALL :
          is_el ? ARR_ERASE_LARGE : ARR_EVAL;
        array_req_o.op <= is_prog ? ARR_PROGRAM : is_otp ? ARR_OTP_PROGRAM :
          is_es ? ARR_ERASE_SMALL : is_el ? ARR_ERASE_LARGE : ARR_EVAL;
        array_req_o.die <= cmd_q.addr[DIE_SEL_BIT];
        array_req_o.addr <= cmd_q.addr[26:0];
        array_req_o.nbytes <= cmd_q.nbytes;
      end
      if (state == S_BUSY && array_done_i && cur_op == ARR_EVAL) begin
        status2[ST2_EVAL_OK] <= eval_ok_i;
      end
    end
  end

  assign status1_o = status1_volatile;
  assign config1_o = config1_volatile;

endmodule // serial_flash_protect_status
